// ### logic/dhis_bus_if.sv
// Parallel system bus plus RGB port between host and display device.
// Assumes both parties run on the same clock; no tristate, host drives data.
`timescale 1ns/1ps
`default_nettype none
interface dhis_bus_if;
  logic [3:0] bus_mode_strap;
  logic cs_n;
  logic rs;
  logic wr_n;
  logic rd_n;
  logic rw;
  logic e;
  logic [17:0] data_bus_pins;
  logic vsync_n;
  logic hsync_n;
  logic pixel_clock;
  logic pix_enable;
  logic busy;
  modport dev (input bus_mode_strap, cs_n, rs, wr_n, rd_n, rw, e, data_bus_pins,
    vsync_n, hsync_n, pixel_clock, pix_enable, output busy);
  modport host (output bus_mode_strap, cs_n, rs, wr_n, rd_n, rw, e, data_bus_pins,
    vsync_n, hsync_n, pixel_clock, pix_enable, input busy);
endinterface
`default_nettype wire

// ### logic/dhis_device_end.sv
// Device end: strap decode, bus transfer assembly, mode control, RGB capture.
// Assumes host pins are synchronous to CLK_SYS_I and held one cycle past strobe.
`timescale 1ns/1ps
`default_nettype none
module dhis_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = wr_ptr == rd_ptr;
  wire push = in_valid_i && !full;
  wire pop = out_ready_i && !empty;
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

module dhis_device_end #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  dhis_bus_if.dev BUS,
  output logic WORD_VALID_O,
  input wire logic WORD_READY_I,
  output logic WORD_RS_O,
  output logic [17:0] WORD_DATA_O,
  output logic PIX_VALID_O,
  output logic [17:0] PIX_DATA_O,
  output logic FRAME_START_O,
  output logic STILL_MODE_O,
  output logic RGB_RAM_MODE_O,
  output logic RGB_DISP_MODE_O,
  output logic VSYNC_MODE_O,
  output logic SERIAL_MODE_O,
  output logic STRAP_ERR_O
);
  logic strap_done;
  logic [3:0] strap;
  logic prev_cs_n, prev_wr_n, prev_e, prev_rw, prev_rs;
  logic [17:0] prev_db;
  logic upper_next;
  logic [8:0] hi_part;
  logic [2:0] zero_run;
  logic [7:0] index;
  logic ram_access_select;
  logic [1:0] display_op_select;
  logic [7:0] hsa, hea, vsa, vea;
  logic prev_pclk, prev_vs_n, prev_hs_n;
  logic [7:0] pix_x, pix_y;
  logic fifo_ready;
  logic [18:0] fifo_out;

  wire is_spi = strap[3:1] == dhis_pkg::STRAP_SPI_TOP;
  wire is_bad = strap[3:1] == dhis_pkg::STRAP_BAD_TOP || strap[3:2] == dhis_pkg::STRAP_BAD_HI;
  wire wide18 = strap == dhis_pkg::STRAP_68_18 || strap == dhis_pkg::STRAP_80_18;
  wire wide16 = strap == dhis_pkg::STRAP_68_16 || strap == dhis_pkg::STRAP_80_16;
  wire narrow9 = strap == dhis_pkg::STRAP_68_9 || strap == dhis_pkg::STRAP_80_9;
  wire narrow8 = strap == dhis_pkg::STRAP_68_8 || strap == dhis_pkg::STRAP_80_8;
  wire narrow = narrow9 || narrow8;
  wire is_80 = strap[1];
  wire par_ok = strap_done && !is_spi && !is_bad;

  // Write strobe release: 80-style write rising, 68-style enable falling
  wire strobe_end = is_80 ? (!prev_wr_n && BUS.wr_n) : (prev_e && !BUS.e && !prev_rw);
  wire xfer = par_ok && !prev_cs_n && strobe_end;
  wire [8:0] lane9 = prev_db[17:9];
  wire [7:0] lane8 = prev_db[17:10];
  wire lane_zero = narrow9 ? (lane9 == 9'h000) : (lane8 == 8'h00);
  wire word_done = xfer && (!narrow || !upper_next);
  // Zero index transfer run on 9-bit bus
  // Zero index transfer run on 8-bit bus
  wire zero_xfer = xfer && narrow && !prev_rs && lane_zero;
  wire resync = zero_xfer && (zero_run == dhis_pkg::SYNC_ZEROS - 3'h1);
  // Toggle per narrow-bus transfer, resync forces upper
  wire next_upper = resync ? 1'b1 : (xfer && narrow) ? !upper_next : upper_next;
  wire [2:0] next_zero_run = (resync || (xfer && !zero_xfer)) ? 3'h0 :
    zero_xfer ? zero_run + 3'h1 : zero_run;

  wire [17:0] data9 = {hi_part, lane9};
  wire [17:0] data8 = {hi_part[7:0], 1'b0, lane8, 1'b0};
  wire [17:0] data16 = {prev_db[17:10], 1'b0, prev_db[8:1], 1'b0};
  wire [17:0] word_data = narrow9 ? data9 : narrow8 ? data8 : wide16 ? data16 : prev_db;
  wire [15:0] ins16 = {word_data[17:10], word_data[8:1]};
  // Instruction writes come only from bus words
  wire ins_wr = word_done && prev_rs;
  wire idx_wr = word_done && !prev_rs;

  wire rgb_op = display_op_select == dhis_pkg::DM_RGB;
  wire vs_fall = prev_vs_n && !BUS.vsync_n;
  wire hs_fall = prev_hs_n && !BUS.hsync_n;
  wire pclk_rise = !prev_pclk && BUS.pixel_clock;
  wire in_win = pix_x >= hsa && pix_x <= hea && pix_y >= vsa && pix_y <= vea;
  wire pix_take = ram_access_select && rgb_op && pclk_rise && BUS.pix_enable && in_win;
  wire frame_edge = vs_fall && (display_op_select == dhis_pkg::DM_VSYNC || rgb_op);

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      strap_done <= 1'b0;
      strap <= dhis_pkg::STRAP_68_16;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      strap <= BUS.bus_mode_strap;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      prev_cs_n <= 1'b1;
      prev_wr_n <= 1'b1;
      prev_e <= 1'b0;
      prev_rw <= 1'b1;
      prev_rs <= 1'b0;
      prev_db <= '0;
      prev_pclk <= 1'b0;
      prev_vs_n <= 1'b1;
      prev_hs_n <= 1'b1;
    end else begin
      prev_cs_n <= BUS.cs_n;
      prev_wr_n <= BUS.wr_n;
      prev_e <= BUS.e;
      prev_rw <= BUS.rw;
      prev_rs <= BUS.rs;
      prev_db <= BUS.data_bus_pins;
      prev_pclk <= BUS.pixel_clock;
      prev_vs_n <= BUS.vsync_n;
      prev_hs_n <= BUS.hsync_n;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      upper_next <= 1'b1;
      zero_run <= 3'h0;
      hi_part <= '0;
    end else begin
      upper_next <= next_upper;
      zero_run <= next_zero_run;
      if (xfer && narrow && upper_next) hi_part <= narrow9 ? lane9 : {1'b0, lane8};
    end
  end

  // Mode and window registers from bus
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      index <= 8'h00;
      ram_access_select <= 1'b0;
      display_op_select <= dhis_pkg::DM_INT;
      hsa <= dhis_pkg::HSA_RST;
      hea <= dhis_pkg::HEA_RST;
      vsa <= dhis_pkg::VSA_RST;
      vea <= dhis_pkg::VEA_RST;
    end else begin
      if (idx_wr) index <= ins16[7:0];
      if (ins_wr && index == dhis_pkg::IDX_EXTIF) begin
        ram_access_select <= ins16[dhis_pkg::RM_BIT];
        display_op_select <= ins16[dhis_pkg::DM_HI:dhis_pkg::DM_LO];
      end
      if (ins_wr && index == dhis_pkg::IDX_HWIN) begin
        hea <= ins16[15:8];
        hsa <= ins16[7:0];
      end
      if (ins_wr && index == dhis_pkg::IDX_VWIN) begin
        vea <= ins16[15:8];
        vsa <= ins16[7:0];
      end
    end
  end

  // Pixel position from sync edges
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pix_x <= 8'h00;
      pix_y <= 8'h00;
      PIX_VALID_O <= 1'b0;
      PIX_DATA_O <= '0;
      FRAME_START_O <= 1'b0;
    end else begin
      if (vs_fall) pix_y <= 8'h00;
      else if (hs_fall) pix_y <= pix_y + 8'h01;
      if (hs_fall || vs_fall) pix_x <= 8'h00;
      else if (pclk_rise && BUS.pix_enable) pix_x <= pix_x + 8'h01;
      PIX_VALID_O <= pix_take;
      if (pix_take) PIX_DATA_O <= BUS.data_bus_pins;
      FRAME_START_O <= frame_edge;
    end
  end

  dhis_fifo #(.WIDTH(19), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK_SYS_I),
    .rst_n(RESETN_I),
    .in_valid_i(word_done),
    .in_ready_o(fifo_ready),
    .in_data_i({prev_rs, word_data}),
    .out_valid_o(WORD_VALID_O),
    .out_ready_i(WORD_READY_I),
    .out_data_o(fifo_out)
  );

  assign BUS.busy = !fifo_ready;
  assign WORD_RS_O = fifo_out[18];
  assign WORD_DATA_O = fifo_out[17:0];
  assign STILL_MODE_O = !ram_access_select && display_op_select == dhis_pkg::DM_INT;
  assign RGB_RAM_MODE_O = ram_access_select && rgb_op;
  assign RGB_DISP_MODE_O = !ram_access_select && rgb_op;
  assign VSYNC_MODE_O = !ram_access_select && display_op_select == dhis_pkg::DM_VSYNC;
  assign SERIAL_MODE_O = strap_done && is_spi;
  assign STRAP_ERR_O = strap_done && is_bad;
endmodule
`default_nettype wire

// ### logic/dhis_host_end.sv
// Host end: splits user words into bus transfers, drives straps and RGB pins.
// Assumes device end samples on the same clock and reports busy when full.
`timescale 1ns/1ps
`default_nettype none
module dhis_host_end (
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  dhis_bus_if.host BUS,
  input wire logic [3:0] STRAP_I,
  input wire logic REQ_VALID_I,
  output logic REQ_READY_O,
  input wire logic REQ_RS_I,
  input wire logic [17:0] REQ_DATA_I,
  input wire logic SYNC_REQ_I,
  input wire logic DISPLAY_ON_I,
  output logic REJECT_O,
  input wire logic RGB_SEL_I,
  input wire logic PIX_VSYNC_N_I,
  input wire logic PIX_HSYNC_N_I,
  input wire logic PIX_CLOCK_I,
  input wire logic PIX_ENABLE_I,
  input wire logic [17:0] PIX_DATA_I
);
  typedef enum logic [1:0] {HS_IDLE, HS_STROBE, HS_HOLD} dhis_hstate_t;
  dhis_hstate_t state;
  logic [2:0] left;
  logic [1:0] cnt;
  logic upper;
  logic rs;
  logic [17:0] word;
  logic [7:0] last_index;
  logic [17:0] db;
  logic sync_pend;

  wire narrow9 = STRAP_I == dhis_pkg::STRAP_68_9 || STRAP_I == dhis_pkg::STRAP_80_9;
  wire narrow8 = STRAP_I == dhis_pkg::STRAP_68_8 || STRAP_I == dhis_pkg::STRAP_80_8;
  wire is_spi = STRAP_I[3:1] == dhis_pkg::STRAP_SPI_TOP;
  wire is_bad = STRAP_I[3:1] == dhis_pkg::STRAP_BAD_TOP || STRAP_I[3:2] == dhis_pkg::STRAP_BAD_HI;
  wire is_80 = STRAP_I[1];
  wire can_go = state == HS_IDLE && !BUS.busy && !is_spi && !is_bad && !RGB_SEL_I;
  wire [15:0] ins16 = {REQ_DATA_I[17:10], REQ_DATA_I[8:1]};
  wire [1:0] dm = ins16[dhis_pkg::DM_HI:dhis_pkg::DM_LO];
  wire ext_wr = REQ_RS_I && last_index == dhis_pkg::IDX_EXTIF;
  wire bad_both = ext_wr && dm == dhis_pkg::DM_BOTH;
  // Refuse RGB entry while display runs
  wire bad_rgb = ext_wr && dm == dhis_pkg::DM_RGB && DISPLAY_ON_I;
  wire start_sync = can_go && sync_pend;
  wire take = can_go && !sync_pend && REQ_VALID_I;
  wire send = take && !bad_both && !bad_rgb;
  // Every word split in two on narrow bus
  wire [2:0] n_xfer = (narrow9 || narrow8) ? 3'h2 : 3'h1;
  wire [17:0] lane = narrow9 ? (upper ? {word[17:9], 9'h000} : {word[8:0], 9'h000}) :
    narrow8 ? (upper ? {word[17:10], 10'h000} : {word[8:1], 10'h000}) : word;

  assign REQ_READY_O = can_go && !sync_pend;

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state <= HS_IDLE;
      left <= 3'h0;
      cnt <= 2'h0;
      upper <= 1'b1;
      rs <= 1'b0;
      word <= '0;
      last_index <= 8'h00;
      sync_pend <= 1'b0;
      REJECT_O <= 1'b0;
    end else begin
      REJECT_O <= take && !send;
      if (SYNC_REQ_I) sync_pend <= 1'b1;
      case (state)
        HS_IDLE: begin
          if (start_sync) begin
            sync_pend <= SYNC_REQ_I;
            rs <= 1'b0;
            word <= '0;
            upper <= 1'b1;
            left <= dhis_pkg::SYNC_ZEROS;
            cnt <= 2'h0;
            state <= HS_STROBE;
          end else if (send) begin
            rs <= REQ_RS_I;
            word <= REQ_DATA_I;
            upper <= 1'b1;
            left <= n_xfer;
            cnt <= 2'h0;
            if (!REQ_RS_I) last_index <= ins16[7:0];
            state <= HS_STROBE;
          end
        end
        HS_STROBE: begin
          cnt <= cnt + 2'h1;
          if (cnt == 2'(dhis_pkg::STROBE_CYC - 1)) state <= HS_HOLD;
        end
        default: begin
          cnt <= 2'h0;
          upper <= !upper;
          left <= left - 3'h1;
          state <= (left == 3'h1) ? HS_IDLE : HS_STROBE;
        end
      endcase
    end
  end

  wire strobing = state == HS_STROBE;
  wire active = state != HS_IDLE;
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      db <= '0;
    end else begin
      db <= RGB_SEL_I ? PIX_DATA_I : lane;
    end
  end

  assign BUS.bus_mode_strap = STRAP_I;
  assign BUS.cs_n = !active;
  assign BUS.rs = rs;
  assign BUS.wr_n = !(strobing && is_80);
  assign BUS.rd_n = 1'b1;
  assign BUS.rw = 1'b0;
  assign BUS.e = strobing && !is_80;
  assign BUS.data_bus_pins = active ? lane : db;
  assign BUS.vsync_n = PIX_VSYNC_N_I;
  assign BUS.hsync_n = PIX_HSYNC_N_I;
  assign BUS.pixel_clock = PIX_CLOCK_I;
  assign BUS.pix_enable = PIX_ENABLE_I;
endmodule
`default_nettype wire

// ### logic/dhis_pkg.sv
// Shared constants for the display host interface select block.
// Assumes both ends sample all link pins on one common system clock.
`default_nettype none
package dhis_pkg;
  localparam int DATA_W = 18;
  localparam int INS_W = 16;
  localparam int HALF9_W = 9;
  localparam int HALF8_W = 8;
  // Bus mode strap patterns
  localparam logic [3:0] STRAP_68_16 = 4'h0;
  localparam logic [3:0] STRAP_68_8 = 4'h1;
  localparam logic [3:0] STRAP_80_16 = 4'h2;
  localparam logic [3:0] STRAP_80_8 = 4'h3;
  localparam logic [3:0] STRAP_68_18 = 4'h8;
  localparam logic [3:0] STRAP_68_9 = 4'h9;
  localparam logic [3:0] STRAP_80_18 = 4'hA;
  localparam logic [3:0] STRAP_80_9 = 4'hB;
  localparam logic [2:0] STRAP_SPI_TOP = 3'h2;
  localparam logic [2:0] STRAP_BAD_TOP = 3'h3;
  localparam logic [1:0] STRAP_BAD_HI = 2'h3;
  // Display operation select codes
  localparam logic [1:0] DM_INT = 2'h0;
  localparam logic [1:0] DM_RGB = 2'h1;
  localparam logic [1:0] DM_VSYNC = 2'h2;
  localparam logic [1:0] DM_BOTH = 2'h3;
  // Instruction indexes and fields
  localparam logic [7:0] IDX_EXTIF = 8'h0C;
  localparam logic [7:0] IDX_HWIN = 8'h44;
  localparam logic [7:0] IDX_VWIN = 8'h45;
  localparam int RM_BIT = 8;
  localparam int DM_HI = 5;
  localparam int DM_LO = 4;
  localparam logic [7:0] HSA_RST = 8'h00;
  localparam logic [7:0] HEA_RST = 8'hAF;
  localparam logic [7:0] VSA_RST = 8'h00;
  localparam logic [7:0] VEA_RST = 8'hDF;
  // Resynchronisation: zero index transfers in a row
  localparam logic [2:0] SYNC_ZEROS = 3'h4;
  // Strobe timing
  localparam int CLK_NS = 20;
  localparam int STROBE_NS = 40;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
endpackage
`default_nettype wire

// ### sim/dhis_link_chk.sv
// Link checker: strobe shapes and pin use on the host/device bus.
// Assumes one clock shared by both ends; instantiated beside the link.
`timescale 1ns/1ps
`default_nettype none
module dhis_link_chk (
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  input wire logic [3:0] bus_mode_strap,
  input wire logic cs_n,
  input wire logic rs,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic rw,
  input wire logic e,
  input wire logic [17:0] data_bus_pins,
  input wire logic busy
);
  wire logic ser = bus_mode_strap[3:1] == dhis_pkg::STRAP_SPI_TOP;
  wire logic bad = bus_mode_strap[3:1] == dhis_pkg::STRAP_BAD_TOP || bus_mode_strap[3:2] == dhis_pkg::STRAP_BAD_HI;
  wire logic nine = bus_mode_strap == dhis_pkg::STRAP_68_9 || bus_mode_strap == dhis_pkg::STRAP_80_9;
  wire logic eight = bus_mode_strap == dhis_pkg::STRAP_68_8 || bus_mode_strap == dhis_pkg::STRAP_80_8;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);
  strobe_select_a: assert property ((!wr_n || e) |-> !cs_n)
    else $error("Strobe without chip select");
  bus_style_a: assert property (bus_mode_strap[1] ? !e : wr_n)
    else $error("Wrong strobe for bus style");
  wr_pulse_a: assert property ($fell(wr_n) |=> !wr_n ##1 wr_n)
    else $error("Write strobe length wrong");
  e_pulse_a: assert property ($rose(e) |=> e ##1 !e)
    else $error("Enable strobe length wrong");
  data_hold_a: assert property (($fell(wr_n) || $rose(e)) |=> ($stable(data_bus_pins) && $stable(rs)) [*2])
    else $error("Data moved during strobe");
  write_only_a: assert property (rd_n && !rw)
    else $error("Read requested on write-only bus");
  ser_quiet_a: assert property (ser |-> cs_n)
    else $error("Parallel select in serial mode");
  bad_quiet_a: assert property (bad |-> cs_n)
    else $error("Parallel select in forbidden mode");
  nine_low_a: assert property ((nine && !cs_n) |-> data_bus_pins[8:0] == 9'h000)
    else $error("Unused low pins not fixed");
  eight_low_a: assert property ((eight && !cs_n) |-> data_bus_pins[9:0] == 10'h000)
    else $error("Unused low pins not fixed");
  cover property ($fell(wr_n));
  cover property ($rose(e));
  cover property (busy);
  cover property (nine && !cs_n);
endmodule
`default_nettype wire

// ### sim/tb.sv
// Testbench: host end and device end joined by the link, word model in a queue.
// Assumes the design files and package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] strap = 4'h8;
  logic req_valid = 1'b0, req_rs = 1'b0, sync_req = 1'b0, display_on = 1'b0, rgb_sel = 1'b0;
  logic [17:0] req_data = 18'h0, pix_data = 18'h0;
  logic pvs_n = 1'b1, phs_n = 1'b1, pclk = 1'b0, pen = 1'b0, word_ready = 1'b0, drain = 1'b1;
  logic req_ready, reject, word_valid, word_rs, pix_valid, frame_start, serial, strap_err;
  logic [17:0] word_data, pix_out;
  wire [3:0] modes;
  int fail_count = 0, comparisons = 0, n_pix = 0, n_frame = 0, n_rej = 0;
  logic [31:0] rng = 32'hBA181539, rng_d = 32'hBA181539;
  logic [18:0] q[$];
  logic [18:0] head;
  logic [3:0] straps [14] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB, 4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hF};
  // Mode table: display on, ram access, display op, expected still/rgb ram/rgb disp/vsync
  logic [7:0] mt [7] = '{8'h08, 8'h54, 8'h12, 8'h21, 8'h31, 8'h91, 8'h08};

  always #10 clk = ~clk;

  dhis_bus_if u_dhis_bus_if ();
  dhis_host_end u_dhis_host_end (.CLK_SYS_I(clk), .RESETN_I(rst_n), .BUS(u_dhis_bus_if.host), .STRAP_I(strap),
    .REQ_VALID_I(req_valid), .REQ_READY_O(req_ready), .REQ_RS_I(req_rs), .REQ_DATA_I(req_data),
    .SYNC_REQ_I(sync_req), .DISPLAY_ON_I(display_on), .REJECT_O(reject), .RGB_SEL_I(rgb_sel),
    .PIX_VSYNC_N_I(pvs_n), .PIX_HSYNC_N_I(phs_n), .PIX_CLOCK_I(pclk), .PIX_ENABLE_I(pen), .PIX_DATA_I(pix_data));
  dhis_device_end #(.FIFO_DEPTH(16)) u_dhis_device_end (.CLK_SYS_I(clk), .RESETN_I(rst_n), .BUS(u_dhis_bus_if.dev),
    .WORD_VALID_O(word_valid), .WORD_READY_I(word_ready), .WORD_RS_O(word_rs), .WORD_DATA_O(word_data),
    .PIX_VALID_O(pix_valid), .PIX_DATA_O(pix_out), .FRAME_START_O(frame_start), .STILL_MODE_O(modes[3]),
    .RGB_RAM_MODE_O(modes[2]), .RGB_DISP_MODE_O(modes[1]), .VSYNC_MODE_O(modes[0]),
    .SERIAL_MODE_O(serial), .STRAP_ERR_O(strap_err));
  dhis_link_chk u_dhis_link_chk (.CLK_SYS_I(clk), .RESETN_I(rst_n), .bus_mode_strap(u_dhis_bus_if.bus_mode_strap),
    .cs_n(u_dhis_bus_if.cs_n), .rs(u_dhis_bus_if.rs), .wr_n(u_dhis_bus_if.wr_n), .rd_n(u_dhis_bus_if.rd_n),
    .rw(u_dhis_bus_if.rw), .e(u_dhis_bus_if.e), .data_bus_pins(u_dhis_bus_if.data_bus_pins), .busy(u_dhis_bus_if.busy));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic logic [17:0] pin(input logic [15:0] v);
    return {v[15:8], 1'b0, v[7:0], 1'b0};
  endfunction

  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic timeout();
    fail_count++;
    $display("Error at %0t ns: wait limit reached", $time);
    wrap_up();
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic send(input logic rs, input logic [17:0] d, input logic keep);
    int n;
    n = 0;
    req_valid = 1'b1;
    req_rs = rs;
    req_data = d;
    do begin
      @(negedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 500);
    if (req_ready !== 1'b1) timeout();
    tick(1);
    req_valid = 1'b0;
    // 8-bit and 16-bit widths drop pins 9 and 0
    if (keep) q.push_back({rs, strap[3] ? d : (d & 18'h3FDFE)});
    tick(1);
  endtask

  task automatic wait_empty();
    int n;
    n = 0;
    while (q.size() > 0 && n < 3000) begin
      tick(1);
      n++;
    end
    if (q.size() > 0) timeout();
    tick(3);
    check(word_valid, 1'b0);
  endtask

  task automatic set_mode(input logic rm, input logic [1:0] dm, input logic keep);
    send(1'b0, pin(16'h000C), 1'b1);
    send(1'b1, pin({7'h0, rm, 2'h0, dm, 4'h0}), keep);
    wait_empty();
  endtask

  task automatic do_reset(input logic [3:0] s);
    rst_n = 1'b0;
    strap = s;
    rgb_sel = 1'b0;
    display_on = 1'b0;
    drain = 1'b1;
    q.delete();
    tick(16);
    rst_n = 1'b1;
    tick(3);
  endtask

  // Word sink with random stalls
  always @(posedge clk) begin
    if (word_valid === 1'b1 && word_ready === 1'b1) begin
      head = q.size() > 0 ? q.pop_front() : 19'h7FFFF;
      check({word_rs, word_data}, head);
    end
    if (pix_valid === 1'b1) n_pix++;
    if (frame_start === 1'b1) n_frame++;
    if (reject === 1'b1) n_rej++;
    #1;
    rng_d = xs(rng_d);
    word_ready = drain & rng_d[0];
  end

  initial begin
    logic [17:0] d, last;
    int exp_pix, exp_rej, x;
    logic rej;
    exp_rej = 0;
    exp_pix = 0;
    last = 18'h0;
    foreach (straps[i]) begin
      do_reset(straps[i]);
      check({serial, strap_err}, {straps[i][3:1] == dhis_pkg::STRAP_SPI_TOP,
        straps[i][3:1] == dhis_pkg::STRAP_BAD_TOP || straps[i][3:2] == dhis_pkg::STRAP_BAD_HI});
      if (straps[i][2]) check(req_ready, 1'b0);
      else begin
        send(1'b0, pin(16'h0022), 1'b1);
        repeat (6) begin
          rng = xs(rng);
          d = rng[17:0];
          if (!rng[20]) d[8:1] = 8'h22;
          send(rng[20], d, 1'b1);
        end
        if (straps[i][0]) begin
          sync_req = 1'b1;
          tick(1);
          sync_req = 1'b0;
          q.push_back(19'h0);
          q.push_back(19'h0);
          rng = xs(rng);
          send(1'b1, rng[17:0], 1'b1);
        end
        wait_empty();
        for (int k = 0; k < 7; k++) begin
          display_on = mt[k][7];
          rej = mt[k][5:4] == 2'h3 || (mt[k][5:4] == 2'h1 && mt[k][7]);
          exp_rej += rej;
          set_mode(mt[k][6], mt[k][5:4], !rej);
          check(modes, mt[k][3:0]);
          check(19'(n_rej), 19'(exp_rej));
        end
      end
    end
    do_reset(dhis_pkg::STRAP_80_18);
    drain = 1'b0;
    send(1'b0, pin(16'h0022), 1'b1);
    repeat (15) begin
      rng = xs(rng);
      send(1'b1, rng[17:0], 1'b1);
    end
    tick(6);
    check({u_dhis_bus_if.busy, req_ready}, 2'b10);
    drain = 1'b1;
    wait_empty();
    // window of columns 0 to 2
    send(1'b0, pin(16'h0044), 1'b1);
    send(1'b1, pin(16'h0200), 1'b1);
    n_pix = 0;
    n_frame = 0;
    set_mode(1'b1, 2'h1, 1'b1);
    check(modes, 4'h4);
    rgb_sel = 1'b1;
    tick(2);
    pvs_n = 1'b0;
    tick(2);
    pvs_n = 1'b1;
    phs_n = 1'b0;
    tick(2);
    phs_n = 1'b1;
    x = 0;
    for (int k = 0; k < 8; k++) begin
      rng = xs(rng);
      pix_data = rng[17:0];
      pen = rng[18] | (k < 4);
      if (pen && x <= 2) exp_pix++;
      if (pen && x <= 2) last = pix_data;
      if (pen) x++;
      tick(3);
      pclk = 1'b1;
      tick(3);
      pclk = 1'b0;
    end
    tick(4);
    check(19'(n_pix), 19'(exp_pix));
    check(pix_out, last);
    check(19'(n_frame), 19'h1);
    check(word_valid, 1'b0);
    rgb_sel = 1'b0;
    pen = 1'b0;
    tick(2);
    set_mode(1'b0, 2'h1, 1'b1);
    check(modes, 4'h2);
    phs_n = 1'b0;
    tick(2);
    phs_n = 1'b1;
    pen = 1'b1;
    tick(3);
    pclk = 1'b1;
    tick(3);
    pclk = 1'b0;
    pen = 1'b0;
    tick(4);
    check(19'(n_pix), 19'(exp_pix));
    set_mode(1'b0, 2'h2, 1'b1);
    check(modes, 4'h1);
    pvs_n = 1'b0;
    tick(2);
    pvs_n = 1'b1;
    tick(3);
    check(19'(n_frame), 19'h2);
    wrap_up();
  end
endmodule
`default_nettype wire
